/* File: hw/swap_dither_trim_regs.sv */
// Purpose: APB register bank for input trim, core swap timing and dither
// Assumes: fuse trim input is static and on the core clock
// Notes:   one wait-free access phase per transfer; outputs all registered

`timescale 1ns/1ns

// Functional notes
// - 8-bit trim for input d, loaded from fuse after reset, read and writable.
// - swap overlap lasts four plus twice the 5-bit overlap field, default eight.
// - overlap field accepts every value from 0 to 31.
// - steering select is delayed by the 5-bit steer field, default seven.
// - steering delay applies only during a swap, never in normal running.
// - steer field accepts every value from 0 to 31.
// - dither bit 0 enables dither injection.
// - dither bit 1 picks large amplitude, zero picks small.
// - dither bit 2 sends rounding error to offset and spurs, zero to noise.
module swap_dither_trim_regs (
    // clock and reset
    input  wire logic                                core_clk_i,
    input  wire logic                                reset_i,
    // apb slave
    input  wire logic                                psel_i,
    input  wire logic                                penable_i,
    input  wire logic                                pwrite_i,
    input  wire logic [swap_dither_pkg::ADDR_W-1:0]  paddr_i,
    input  wire logic [swap_dither_pkg::DATA_W-1:0]  pwdata_i,
    input  wire logic [3:0]                          pstrb_i,
    output logic      [swap_dither_pkg::DATA_W-1:0]  prdata_o,
    output logic                                     pready_o,
    output logic                                     pslverr_o,
    // fuse and swap request
    input  wire logic [7:0]                          fuse_trim_d_i,
    input  wire logic                                swap_req_i,
    // converter controls
    output logic      [7:0]                          trim_d_o,
    output logic                                     cal_enable_o,
    output logic                                     dither_enable_o,
    output logic                                     dither_large_o,
    output logic                                     dither_round_dc_o,
    output logic                                     overlap_o,
    output logic                                     steer_sel_o,
    output logic                                     active_core_o,
    output logic                                     swap_busy_o
);

    typedef enum logic [0:0] {
        SWAP_IDLE,
        SWAP_RUN
    } swap_state_type;

    // bus state
    logic [swap_dither_pkg::DATA_W-1:0] prdata_nxt;
    logic                               pready_nxt;
    logic                               pslverr_nxt;

    // register state
    logic [7:0] trim_nxt;
    logic [4:0] overlap_r;
    logic [4:0] overlap_nxt;
    logic [4:0] steer_r;
    logic [4:0] steer_nxt;
    logic [2:0] dither_r;
    logic [2:0] dither_nxt;
    logic       cal_nxt;
    logic       load_pend_r;
    logic       load_pend_nxt;

    // swap state
    swap_state_type state_r;
    swap_state_type state_nxt;
    logic           target_r;
    logic           target_nxt;
    logic           core_nxt;
    logic           steer_sel_nxt;
    logic           overlap_nxt_o;
    logic           busy_nxt;
    logic           req_d_r;

    // strobes
    logic       req_s;
    logic       setup_c;
    logic       done_c;
    logic       wr_c;
    logic       go_c;
    logic       start_c;
    logic       ov_active;
    logic       dl_active;
    logic [6:0] ov_len_c;
    logic [6:0] dl_len_c;

    function automatic logic addr_mapped(input logic [swap_dither_pkg::ADDR_W-1:0] a);
        return (a == swap_dither_pkg::ADDR_TRIM_D)
            || (a == swap_dither_pkg::ADDR_OVERLAP)
            || (a == swap_dither_pkg::ADDR_STEER)
            || (a == swap_dither_pkg::ADDR_DITHER)
            || (a == swap_dither_pkg::ADDR_SWAP_CTRL)
            || (a == swap_dither_pkg::ADDR_SWAP_STAT);
    endfunction : addr_mapped

    function automatic logic wr_hit(input logic                               w,
                                    input logic [swap_dither_pkg::ADDR_W-1:0] a,
                                    input logic [swap_dither_pkg::ADDR_W-1:0] target);
        return w && (a == target);
    endfunction : wr_hit

    // swap request from the calibration sequencer runs on another clock
    pin_sync2 u_req_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .async_i    (swap_req_i),
        .sync_o     (req_s)
    );

    assign setup_c = psel_i & ~penable_i;
    assign done_c  = psel_i & penable_i & pready_o;
    // a narrow write without lane 0 changes nothing
    assign wr_c    = done_c & pwrite_i & pstrb_i[0] & ~pslverr_o;
    assign go_c    = wr_hit(wr_c, paddr_i, swap_dither_pkg::ADDR_SWAP_CTRL)
                     & pwdata_i[swap_dither_pkg::CTRL_GO_BIT];
    // a request while a swap runs is dropped, not queued
    assign start_c = (state_r == SWAP_IDLE) & cal_enable_o & ((req_s & ~req_d_r) | go_c);

    // bus answer: data and error latched in setup, ready in access
    always_comb begin
        prdata_nxt  = prdata_o;
        pslverr_nxt = pslverr_o;
        pready_nxt  = 1'b0;
        if (setup_c) begin
            pready_nxt  = 1'b1;
            pslverr_nxt = ~addr_mapped(paddr_i);
            prdata_nxt  = '0;
            unique case (paddr_i)
                swap_dither_pkg::ADDR_TRIM_D:    prdata_nxt[7:0] = trim_d_o;
                swap_dither_pkg::ADDR_OVERLAP:   prdata_nxt[4:0] = overlap_r;
                swap_dither_pkg::ADDR_STEER:     prdata_nxt[4:0] = steer_r;
                swap_dither_pkg::ADDR_DITHER:    prdata_nxt[2:0] = dither_r;
                swap_dither_pkg::ADDR_SWAP_CTRL: begin
                    prdata_nxt[swap_dither_pkg::CTRL_CAL_BIT] = cal_enable_o;
                end
                swap_dither_pkg::ADDR_SWAP_STAT: begin
                    prdata_nxt[swap_dither_pkg::STAT_BUSY_BIT]  = swap_busy_o;
                    prdata_nxt[swap_dither_pkg::STAT_OVL_BIT]   = overlap_o;
                    prdata_nxt[swap_dither_pkg::STAT_STEER_BIT] = steer_sel_o;
                    prdata_nxt[swap_dither_pkg::STAT_CORE_BIT]  = active_core_o;
                end
                default: prdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_o  <= '0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            prdata_o  <= prdata_nxt;
            pready_o  <= pready_nxt;
            pslverr_o <= pslverr_nxt;
        end
    end

    // registers; reserved bits are not stored and read as zero
    always_comb begin
        trim_nxt      = trim_d_o;
        overlap_nxt   = overlap_r;
        steer_nxt     = steer_r;
        dither_nxt    = dither_r;
        cal_nxt       = cal_enable_o;
        load_pend_nxt = 1'b0;
        if (load_pend_r) begin
            trim_nxt = fuse_trim_d_i;
        end
        if (wr_hit(wr_c, paddr_i, swap_dither_pkg::ADDR_TRIM_D)) begin
            trim_nxt = pwdata_i[7:0];
        end
        // full 5-bit range taken, no clamp; host
        if (wr_hit(wr_c, paddr_i, swap_dither_pkg::ADDR_OVERLAP)) begin
            overlap_nxt = pwdata_i[4:0];
        end
        if (wr_hit(wr_c, paddr_i, swap_dither_pkg::ADDR_STEER)) begin
            steer_nxt = pwdata_i[4:0];
        end
        if (wr_hit(wr_c, paddr_i, swap_dither_pkg::ADDR_DITHER)) begin
            dither_nxt = pwdata_i[2:0];
        end
        if (wr_hit(wr_c, paddr_i, swap_dither_pkg::ADDR_SWAP_CTRL)) begin
            cal_nxt = pwdata_i[swap_dither_pkg::CTRL_CAL_BIT];
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            trim_d_o     <= swap_dither_pkg::RST_TRIM_D;
            overlap_r    <= swap_dither_pkg::RST_OVERLAP;
            steer_r      <= swap_dither_pkg::RST_STEER;
            dither_r     <= swap_dither_pkg::RST_DITHER;
            cal_enable_o <= 1'b0;
            load_pend_r  <= 1'b1;
        end else begin
            trim_d_o     <= trim_nxt;
            overlap_r    <= overlap_nxt;
            steer_r      <= steer_nxt;
            dither_r     <= dither_nxt;
            cal_enable_o <= cal_nxt;
            load_pend_r  <= load_pend_nxt;
        end
    end

    assign dither_enable_o   = dither_r[swap_dither_pkg::DITH_EN_BIT];
    assign dither_large_o    = dither_r[swap_dither_pkg::DITH_AMP_BIT];
    assign dither_round_dc_o = dither_r[swap_dither_pkg::DITH_RND_BIT];

    // swap timers
    assign ov_len_c = swap_dither_pkg::OVERLAP_BASE + {1'b0, overlap_r, 1'b0};
    assign dl_len_c = {2'b00, steer_r};

    swap_timer #(
        .WIDTH (swap_dither_pkg::CNT_W)
    ) u_overlap_timer (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .load_i     (start_c),
        .value_i    (ov_len_c),
        .active_o   (ov_active)
    );

    swap_timer #(
        .WIDTH (swap_dither_pkg::CNT_W)
    ) u_steer_timer (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .load_i     (start_c),
        .value_i    (dl_len_c),
        .active_o   (dl_active)
    );

    // swap sequencer
    always_comb begin
        state_nxt     = state_r;
        target_nxt    = target_r;
        core_nxt      = active_core_o;
        steer_sel_nxt = steer_sel_o;
        overlap_nxt_o = ov_active;
        unique case (state_r)
            SWAP_IDLE: begin
                steer_sel_nxt = active_core_o;
                if (start_c) begin
                    state_nxt  = SWAP_RUN;
                    target_nxt = ~active_core_o;
                end
            end
            SWAP_RUN: begin
                if (!dl_active) begin
                    steer_sel_nxt = target_r;
                end
                if (!ov_active && !dl_active && (steer_sel_o == target_r)) begin
                    state_nxt = SWAP_IDLE;
                    core_nxt  = target_r;
                end
            end
        endcase
        busy_nxt = (state_nxt == SWAP_RUN);
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r       <= SWAP_IDLE;
            target_r      <= 1'b0;
            active_core_o <= 1'b0;
            steer_sel_o   <= 1'b0;
            overlap_o     <= 1'b0;
            swap_busy_o   <= 1'b0;
            req_d_r       <= 1'b0;
        end else begin
            state_r       <= state_nxt;
            target_r      <= target_nxt;
            active_core_o <= core_nxt;
            steer_sel_o   <= steer_sel_nxt;
            overlap_o     <= overlap_nxt_o;
            swap_busy_o   <= busy_nxt;
            req_d_r       <= req_s;
        end
    end

    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    logic [6:0] ov_len_h;
    logic [7:0] since_h;
    logic [4:0] ov_exp_h;
    logic [4:0] dl_exp_h;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ov_len_h <= '0;
            since_h  <= '0;
            ov_exp_h <= '0;
            dl_exp_h <= '0;
        end else begin
            if (overlap_nxt_o) begin
                ov_len_h <= overlap_o ? ov_len_h + 7'h01 : 7'h01;
            end
            if (overlap_nxt_o && !overlap_o) begin
                since_h <= '0;
            end else if (since_h != 8'hff) begin
                since_h <= since_h + 8'h01;
            end
            if (start_c) begin
                ov_exp_h <= overlap_r;
                dl_exp_h <= steer_r;
            end
        end
    end

    sequence apb_setup_s;
        psel_i && !penable_i;
    endsequence

    sequence swap_start_s;
        start_c;
    endsequence

    apb_ready_a: assert property (apb_setup_s |=> pready_o)
        else $error("no ready after setup");

    trim_fuse_a: assert property ($fell(load_pend_r) |-> trim_d_o == $past(fuse_trim_d_i))
        else $error("trim not loaded from fuse");

    swap_overlap_a: assert property (swap_start_s |-> ##2 overlap_o)
        else $error("overlap did not start");

    overlap_len_a: assert property ($fell(overlap_o) |->
        ov_len_h == swap_dither_pkg::OVERLAP_BASE + {1'b0, ov_exp_h, 1'b0})
        else $error("overlap length wrong");

    steer_delay_a: assert property (swap_busy_o && $changed(steer_sel_o) |->
        since_h == {3'b000, dl_exp_h})
        else $error("steer delay wrong");

    steer_idle_a: assert property (!swap_busy_o && !$past(swap_busy_o) |->
        steer_sel_o == active_core_o)
        else $error("steer delayed outside swap");

    overlap_max_a: assert property (wr_hit(wr_c, paddr_i, swap_dither_pkg::ADDR_OVERLAP)
        && pwdata_i[4:0] == 5'h1f |=> overlap_r == 5'h1f)
        else $error("overlap 31 not kept");

    steer_max_a: assert property (wr_hit(wr_c, paddr_i, swap_dither_pkg::ADDR_STEER)
        && pwdata_i[4:0] == 5'h1f |=> steer_r == 5'h1f)
        else $error("steer 31 not kept");

    dither_en_a: assert property (wr_hit(wr_c, paddr_i, swap_dither_pkg::ADDR_DITHER)
        |=> dither_enable_o == $past(pwdata_i[0]))
        else $error("dither enable not taken");

    dither_mode_a: assert property (wr_hit(wr_c, paddr_i, swap_dither_pkg::ADDR_DITHER)
        |=> {dither_round_dc_o, dither_large_o} == $past(pwdata_i[2:1]))
        else $error("dither mode not taken");

endmodule : swap_dither_trim_regs

/* File: hw/swap_dither_pkg.sv */
// Purpose: shared constants of the swap, dither and trim register bank
// Assumes: 32-bit APB, 8-bit registers in the low byte of each word
// Notes:   byte address is four times the register index

package swap_dither_pkg;

    // bus shape
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;

    // register indices
    localparam logic [9:0] IDX_TRIM_D    = 10'h081;
    localparam logic [9:0] IDX_OVERLAP   = 10'h09a;
    localparam logic [9:0] IDX_STEER     = 10'h09b;
    localparam logic [9:0] IDX_DITHER    = 10'h09d;
    localparam logic [9:0] IDX_SWAP_CTRL = 10'h0a0;
    localparam logic [9:0] IDX_SWAP_STAT = 10'h0a1;

    // byte addresses
    localparam logic [ADDR_W-1:0] ADDR_TRIM_D    = {IDX_TRIM_D, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_OVERLAP   = {IDX_OVERLAP, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STEER     = {IDX_STEER, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DITHER    = {IDX_DITHER, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_SWAP_CTRL = {IDX_SWAP_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_SWAP_STAT = {IDX_SWAP_STAT, 2'b00};

    // field widths and reset values
    localparam int         DLY_W       = 5;
    localparam int         DITH_W      = 3;
    localparam logic [7:0] RST_TRIM_D  = 8'h00;
    localparam logic [4:0] RST_OVERLAP = 5'h08;
    localparam logic [4:0] RST_STEER   = 5'h07;
    localparam logic [2:0] RST_DITHER  = 3'h0;

    // bit positions
    localparam int DITH_EN_BIT    = 0;
    localparam int DITH_AMP_BIT   = 1;
    localparam int DITH_RND_BIT   = 2;
    localparam int CTRL_CAL_BIT   = 0;
    localparam int CTRL_GO_BIT    = 1;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_OVL_BIT   = 1;
    localparam int STAT_STEER_BIT = 2;
    localparam int STAT_CORE_BIT  = 3;

    // swap timing in core clock cycles
    localparam int         CNT_W        = 7;
    localparam logic [6:0] OVERLAP_BASE = 7'h04;

endpackage : swap_dither_pkg

/* File: hw/pin_sync2.sv */
// Purpose: two-flop synchroniser for one level from outside the clock domain
// Assumes: input is a slow level
// Notes:   first flop feeds only the second

`timescale 1ns/1ns

module pin_sync2 (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    // level
    input  wire logic async_i,
    output logic      sync_o
);

    logic meta_r;
    logic meta_nxt;
    logic sync_nxt;

    always_comb begin
        meta_nxt = async_i;
        sync_nxt = meta_r;
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_r <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            sync_o <= sync_nxt;
        end
    end

endmodule : pin_sync2

/* File: hw/swap_timer.sv */
// Purpose: loadable down counter that marks a span of core clock cycles
// Assumes: load wins over counting
// Notes:   active while the count is not zero, so a load of n gives n cycles

`timescale 1ns/1ns

module swap_timer #(
    parameter int WIDTH = 7
) (
    // clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             reset_i,
    // control
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] value_i,
    output logic                  active_o
);

    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (load_i) begin
            cnt_nxt = value_i;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - WIDTH'(1);
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign active_o = (cnt_r != '0);

endmodule : swap_timer

/* File: dv/tb.sv */
// Purpose: self-checking bench for the swap, dither and trim register bank
// Assumes: apb slave answers in its own time, swap timing counted on the core clock
// Notes:   no partner model, the bench drives every port itself

`timescale 1ns/1ns

module tb;
    // fuse value is arbitrary, only needs to differ from the reset value
    localparam logic [7:0] fuse_val = 8'h5a;

    logic        core_clk_i;
    logic        reset_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [3:0]  pstrb_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [7:0]  fuse_trim_d_i;
    logic        swap_req_i;
    logic [7:0]  trim_d_o;
    logic        cal_enable_o;
    logic        dither_enable_o;
    logic        dither_large_o;
    logic        dither_round_dc_o;
    logic        overlap_o;
    logic        steer_sel_o;
    logic        active_core_o;
    logic        swap_busy_o;
    logic [31:0] rdat;
    logic        rerr;
    int          err_total;
    int          n_checks;
    int          cycles;

    swap_dither_trim_regs u_dut (
        .core_clk_i        (core_clk_i),
        .reset_i           (reset_i),
        .psel_i            (psel_i),
        .penable_i         (penable_i),
        .pwrite_i          (pwrite_i),
        .paddr_i           (paddr_i),
        .pwdata_i          (pwdata_i),
        .pstrb_i           (pstrb_i),
        .prdata_o          (prdata_o),
        .pready_o          (pready_o),
        .pslverr_o         (pslverr_o),
        .fuse_trim_d_i     (fuse_trim_d_i),
        .swap_req_i        (swap_req_i),
        .trim_d_o          (trim_d_o),
        .cal_enable_o      (cal_enable_o),
        .dither_enable_o   (dither_enable_o),
        .dither_large_o    (dither_large_o),
        .dither_round_dc_o (dither_round_dc_o),
        .overlap_o         (overlap_o),
        .steer_sel_o       (steer_sel_o),
        .active_core_o     (active_core_o),
        .swap_busy_o       (swap_busy_o)
    );

    always #2 core_clk_i = ~core_clk_i;

    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    // a hung handshake ends the run here; swap waits have their own limits
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            err_total++;
            $display("CHECK FAILED at %0t: timeout", $time);
            complete_run;
        end
    end

    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // pready and read data are taken at the rising edge that completes the access;
    // only the bench timeout ends a wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge core_clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= d;
        pstrb_i   <= s;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge core_clk_i);
        end while (pready_o !== 1'b1);
        rdat = prdata_o;
        rerr = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0, 4'hf);
        check(rdat, exp, what);
    endtask : rd_chk

    // overlap and steer fields are changed only with calibration off
    task automatic swap_run(input logic [4:0] ov, input logic [4:0] st);
        int   i;
        int   hi;
        int   tog;
        bit   seen;
        logic c1;
        logic s0;
        wr(swap_dither_pkg::ADDR_SWAP_CTRL, 32'h0);
        wr(swap_dither_pkg::ADDR_OVERLAP, {27'h0, ov});
        wr(swap_dither_pkg::ADDR_STEER, {27'h0, st});
        wr(swap_dither_pkg::ADDR_SWAP_CTRL, 32'h1);
        rd_chk(swap_dither_pkg::ADDR_SWAP_CTRL, 32'h1, "cal enable read");
        check({31'h0, cal_enable_o}, 32'h1, "cal enable pin");
        c1 = ~active_core_o;
        s0 = steer_sel_o;
        check({31'h0, s0}, {31'h0, ~c1}, "idle steer follows core");
        wr(swap_dither_pkg::ADDR_SWAP_CTRL, 32'h3);
        hi   = 0;
        tog  = -1;
        seen = 1'b0;
        i    = 0;
        repeat (200) begin
            @(negedge core_clk_i);
            if (overlap_o === 1'b1) seen = 1'b1;
            if (seen) begin
                if (overlap_o === 1'b1) hi++;
                if (tog < 0 && steer_sel_o !== s0) tog = i;
                i++;
            end
            if (seen && swap_busy_o !== 1'b1) break;
        end
        check(hi, 4 + 2 * ov, "overlap length");
        check(tog, {27'h0, st}, "steer delay");
        check({31'h0, active_core_o}, {31'h0, c1}, "core swapped");
        check({31'h0, steer_sel_o}, {31'h0, active_core_o}, "steer after swap");
        rd_chk(swap_dither_pkg::ADDR_SWAP_STAT, {28'h0, c1, c1, 2'b00}, "status after swap");
        $display("test swap ov %0d st %0d done", ov, st);
    endtask : swap_run

    initial begin
        int   n;
        logic c1;
        core_clk_i    = 1'b0;
        reset_i       = 1'b1;
        psel_i        = 1'b0;
        penable_i     = 1'b0;
        pwrite_i      = 1'b0;
        paddr_i       = 12'h000;
        pwdata_i      = 32'h0;
        pstrb_i       = 4'h0;
        fuse_trim_d_i = fuse_val;
        swap_req_i    = 1'b0;
        err_total     = 0;
        n_checks      = 0;
        cycles        = 0;
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        rd_chk(swap_dither_pkg::ADDR_TRIM_D, {24'h0, fuse_val}, "trim fuse");
        rd_chk(swap_dither_pkg::ADDR_OVERLAP, 32'h08, "overlap reset");
        rd_chk(swap_dither_pkg::ADDR_STEER, 32'h07, "steer reset");
        rd_chk(swap_dither_pkg::ADDR_DITHER, 32'h0, "dither reset");
        $display("test reset values done");
        wr(swap_dither_pkg::ADDR_TRIM_D, 32'hffff_ffa5);
        rd_chk(swap_dither_pkg::ADDR_TRIM_D, 32'ha5, "trim write");
        check({24'h0, trim_d_o}, 32'ha5, "trim pin");
        apb(1'b1, swap_dither_pkg::ADDR_TRIM_D, 32'h3c, 4'he);
        rd_chk(swap_dither_pkg::ADDR_TRIM_D, 32'ha5, "strobe off");
        wr(swap_dither_pkg::ADDR_OVERLAP, 32'h1f);
        rd_chk(swap_dither_pkg::ADDR_OVERLAP, 32'h1f, "overlap max");
        wr(swap_dither_pkg::ADDR_STEER, 32'h00);
        rd_chk(swap_dither_pkg::ADDR_STEER, 32'h0, "steer zero");
        $display("test field widths done");
        for (int k = 0; k < 8; k++) begin
            wr(swap_dither_pkg::ADDR_DITHER, k);
            rd_chk(swap_dither_pkg::ADDR_DITHER, k, "dither read");
            check({29'h0, dither_round_dc_o, dither_large_o, dither_enable_o}, k,
                  "dither pins");
        end
        $display("test dither modes done");
        apb(1'b0, 12'h400, 32'h0, 4'hf);
        check(rdat, 32'h0, "unmapped data");
        check({31'h0, rerr}, 32'h1, "unmapped error");
        apb(1'b1, swap_dither_pkg::ADDR_DITHER | 12'h001, 32'h0, 4'hf);
        check({31'h0, rerr}, 32'h1, "misaligned error");
        rd_chk(swap_dither_pkg::ADDR_DITHER, 32'h7, "misaligned ignored");
        wr(swap_dither_pkg::ADDR_SWAP_CTRL, 32'h2);
        repeat (6) @(negedge core_clk_i);
        check({31'h0, swap_busy_o}, 32'h0, "swap without cal");
        $display("test refusals done");
        swap_run(5'd8, 5'd7);
        swap_run(5'd0, 5'd0);
        swap_run(5'd31, 5'd31);
        swap_run(5'd0, 5'd31);
        swap_run(5'd31, 5'd0);
        // the pin path crosses a synchroniser, so only the outcome is timed loosely
        @(posedge core_clk_i);
        c1 = ~active_core_o;
        swap_req_i <= 1'b1;
        n = 0;
        while (swap_busy_o !== 1'b1 && n < 20) begin
            @(negedge core_clk_i);
            n++;
        end
        while (swap_busy_o === 1'b1 && n < 300) begin
            @(negedge core_clk_i);
            n++;
        end
        @(posedge core_clk_i);
        swap_req_i <= 1'b0;
        check({31'h0, active_core_o}, {31'h0, c1}, "pin swap");
        $display("test pin request done");
        complete_run;
    end
endmodule : tb
